//--- lane_sample_mapper.sv
// transport mapper placing converter samples onto serial output lanes
`timescale 1ns/1ps
module lane_sample_mapper
   import lane_map_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic [MODE_W-1:0] link_mode_setting,
   input  wire logic              link_running,
   input  wire logic              frame_valid,
   input  wire ddc_frame_t        ddc_frame,
   input  wire byp_frame_t        byp_frame,
   output lane_bus_t              lanes,
   output logic                   lane_valid,
   output layout_t                active_layout,
   output logic                   mode_unsupported
);
   logic [MODE_W-1:0] active_mode;
   logic [MODE_W-1:0] next_active_mode;
   layout_t           next_active_layout;
   logic              next_mode_unsupported;
   lane_bus_t         next_lanes;
   logic              next_lane_valid;
   logic [BYP_GROUPS-1:0][GROUP_WORDS-1:0][LANE_W-1:0] byp_words;

   // mode group: latched only while the link is stopped
   always_comb begin
      next_active_mode      = active_mode;
      next_active_layout    = active_layout;
      next_mode_unsupported = mode_unsupported;
      if (!link_running) begin
         next_active_mode      = link_mode_setting;
         next_active_layout    = layout_of(link_mode_setting);
         next_mode_unsupported = (layout_of(link_mode_setting) == LAYOUT_NONE);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         active_mode      <= MODE_RESET;
         active_layout    <= LAYOUT_NONE;
         mode_unsupported <= 1'b1;
      end else begin
         active_mode      <= next_active_mode;
         active_layout    <= next_active_layout;
         mode_unsupported <= next_mode_unsupported;
      end
   end

   // group g: side g%2 (even samples on a), half g/2 of the frame
   for (genvar g = 0; g < BYP_GROUPS; g++) begin : g_pack
      logic [GROUP_SAMPLES-1:0][RAW_W-1:0] grp;
      for (genvar k = 0; k < GROUP_SAMPLES; k++) begin : g_smp
         assign grp[k] = byp_frame.smp[(g/2)*(2*GROUP_SAMPLES) + 2*k + (g%2)];
      end
      word_packer u_pack (
         .smp  (grp),
         .word (byp_words[g])
      );
   end

   // lane group
   always_comb begin
      next_lanes      = '0;
      next_lane_valid = frame_valid && link_running && (active_layout != LAYOUT_NONE);
      unique case (active_layout)
         LAYOUT_NONE: begin
            next_lanes = '0;
         end
         LAYOUT_L4: begin
            next_lanes.a_side[0] = {ddc_frame.ai[0], ddc_frame.or_a0[0]};
            next_lanes.a_side[1] = {ddc_frame.aq[0], ddc_frame.or_a1[0]};
            next_lanes.b_side[0] = {ddc_frame.bi[0], ddc_frame.or_b0[0]};
            next_lanes.b_side[1] = {ddc_frame.bq[0], ddc_frame.or_b1[0]};
         end
         LAYOUT_L8: begin
            for (int i = 0; i < 2; i++) begin
               next_lanes.a_side[i]   = {ddc_frame.ai[i], ddc_frame.or_a0[i]};
               next_lanes.a_side[i+2] = {ddc_frame.aq[i], ddc_frame.or_a1[i]};
               next_lanes.b_side[i]   = {ddc_frame.bi[i], ddc_frame.or_b0[i]};
               next_lanes.b_side[i+2] = {ddc_frame.bq[i], ddc_frame.or_b1[i]};
            end
         end
         LAYOUT_L16: begin
            for (int i = 0; i < DDC_DEPTH; i++) begin
               next_lanes.a_side[i]   = {ddc_frame.ai[i], ddc_frame.or_a0[i]};
               next_lanes.a_side[i+4] = {ddc_frame.aq[i], ddc_frame.or_a1[i]};
               next_lanes.b_side[i]   = {ddc_frame.bi[i], ddc_frame.or_b0[i]};
               next_lanes.b_side[i+4] = {ddc_frame.bq[i], ddc_frame.or_b1[i]};
            end
         end
         LAYOUT_BYP: begin
            for (int w = 0; w < GROUP_WORDS; w++) begin
               next_lanes.a_side[w]             = byp_words[0][w];
               next_lanes.b_side[w]             = byp_words[1][w];
               next_lanes.a_side[w+GROUP_WORDS] = byp_words[2][w];
               next_lanes.b_side[w+GROUP_WORDS] = byp_words[3][w];
            end
         end
         default: begin
            next_lanes      = '0;
            next_lane_valid = 1'b0;
         end
      endcase
      if (!next_lane_valid) begin
         next_lanes = '0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         lanes      <= '0;
         lane_valid <= 1'b0;
      end else begin
         lanes      <= next_lanes;
         lane_valid <= next_lane_valid;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   mode_hold_a: assert property (link_running && $past(link_running) |-> $stable(active_layout))
      else $error("layout changed while link running");
   mode_latch_a: assert property (!link_running |=> active_mode == $past(link_mode_setting))
      else $error("mode not taken while link stopped");
   l4_map_a: assert property (frame_valid && link_running && active_layout == LAYOUT_L4 |=>
      lane_valid && lanes.a_side[1] == {$past(ddc_frame.aq[0]), $past(ddc_frame.or_a1[0])}
      && lanes.b_side[1] == {$past(ddc_frame.bq[0]), $past(ddc_frame.or_b1[0])}
      && lanes.a_side[2] == LANE_IDLE)
      else $error("four-lane map wrong");
   alias_l4_a: assert property ($rose(link_running)
      && $past(link_mode_setting) == MODE_D8_L4_E |-> active_layout == LAYOUT_L4)
      else $error("alias mode not four-lane");
   l8_map_a: assert property (frame_valid && link_running && active_layout == LAYOUT_L8 |=>
      lanes.a_side[2] == {$past(ddc_frame.aq[0]), $past(ddc_frame.or_a1[0])}
      && lanes.b_side[1] == {$past(ddc_frame.bi[1]), $past(ddc_frame.or_b0[1])})
      else $error("eight-lane map wrong");
   alias_l8_a: assert property (!link_running && link_mode_setting == MODE_D8_L8_C
      |=> active_layout == LAYOUT_L8)
      else $error("alias mode not eight-lane");
   l16_map_a: assert property (frame_valid && link_running && active_layout == LAYOUT_L16 |=>
      lanes.a_side[7] == {$past(ddc_frame.aq[3]), $past(ddc_frame.or_a1[3])}
      && lanes.b_side[3] == {$past(ddc_frame.bi[3]), $past(ddc_frame.or_b0[3])})
      else $error("sixteen-lane map wrong");
   byp_side_a: assert property (frame_valid && link_running && active_layout == LAYOUT_BYP |=>
      lanes.a_side[3][15:4] == $past(byp_frame.smp[8])
      && lanes.b_side[0][15:4] == $past(byp_frame.smp[1]) && lanes.a_side[6] == LANE_IDLE)
      else $error("bypass side split wrong");
   byp_pack_a: assert property (frame_valid && link_running && active_layout == LAYOUT_BYP |=>
      lanes.a_side[1] == {$past(byp_frame.smp[2][7:0]), $past(byp_frame.smp[4][11:4])}
      && lanes.b_side[5][11:0] == $past(byp_frame.smp[15]))
      else $error("bypass packing wrong");
   idle_a: assert property (!lane_valid |-> lanes == '0)
      else $error("lanes not idle without data");

   l4_run_c: cover property (active_layout == LAYOUT_L4 && lane_valid [*3]);
   byp_run_c: cover property (active_layout == LAYOUT_BYP && lane_valid);
   relink_c: cover property (lane_valid ##1 !link_running ##1 link_running ##1 lane_valid);
endmodule

//--- lane_map_pkg.sv
// constants, carriers and the 12-bit word packer for the lane sample mapper
// Operation
// - four-lane mode 14: AI, AQ, BI, BQ lanes
// - modes 49, 57, 60, 67 equal mode 14
// - eight-lane mode 15: I0, I1, Q0, Q1
// - modes 55 and 58 equal mode 15
// - sixteen-lane mode 16: I0-3 then Q0-3
// - mode 19: even samples A, odd B
// - three words hold four 12-bit samples
package lane_map_pkg;
   localparam int SAMPLE_W       = 15;
   localparam int RAW_W          = 12;
   localparam int LANE_W         = 16;
   localparam int LANES_PER_SIDE = 8;
   localparam int MODE_W         = 7;
   localparam int BYP_SAMPLES    = 16;
   localparam int GROUP_SAMPLES  = 4;
   localparam int GROUP_WORDS    = 3;
   localparam int BYP_GROUPS     = 4;
   localparam int DDC_DEPTH      = 4;

   localparam logic [MODE_W-1:0] MODE_D8_L4    = 7'h0E;
   localparam logic [MODE_W-1:0] MODE_D8_L4_B  = 7'h31;
   localparam logic [MODE_W-1:0] MODE_D8_L4_C  = 7'h39;
   localparam logic [MODE_W-1:0] MODE_D8_L4_D  = 7'h3C;
   localparam logic [MODE_W-1:0] MODE_D8_L4_E  = 7'h43;
   localparam logic [MODE_W-1:0] MODE_D8_L8    = 7'h0F;
   localparam logic [MODE_W-1:0] MODE_D8_L8_B  = 7'h37;
   localparam logic [MODE_W-1:0] MODE_D8_L8_C  = 7'h3A;
   localparam logic [MODE_W-1:0] MODE_D8_L16   = 7'h10;
   localparam logic [MODE_W-1:0] MODE_BYP_L12  = 7'h13;
   localparam logic [MODE_W-1:0] MODE_RESET    = 7'h00;
   localparam logic [LANE_W-1:0] LANE_IDLE     = 16'h0000;

   typedef enum logic [2:0] {
      LAYOUT_NONE = 3'b000,
      LAYOUT_L4   = 3'b001,
      LAYOUT_L8   = 3'b010,
      LAYOUT_L16  = 3'b011,
      LAYOUT_BYP  = 3'b100
   } layout_t;

   typedef struct packed {
      logic [DDC_DEPTH-1:0][SAMPLE_W-1:0] ai;
      logic [DDC_DEPTH-1:0][SAMPLE_W-1:0] aq;
      logic [DDC_DEPTH-1:0][SAMPLE_W-1:0] bi;
      logic [DDC_DEPTH-1:0][SAMPLE_W-1:0] bq;
      logic [DDC_DEPTH-1:0]               or_a0;
      logic [DDC_DEPTH-1:0]               or_a1;
      logic [DDC_DEPTH-1:0]               or_b0;
      logic [DDC_DEPTH-1:0]               or_b1;
   } ddc_frame_t;

   typedef struct packed {
      logic [BYP_SAMPLES-1:0][RAW_W-1:0] smp;
   } byp_frame_t;

   typedef struct packed {
      logic [LANES_PER_SIDE-1:0][LANE_W-1:0] a_side;
      logic [LANES_PER_SIDE-1:0][LANE_W-1:0] b_side;
   } lane_bus_t;

   function automatic layout_t layout_of(input logic [MODE_W-1:0] mode);
      layout_t l;
      l = LAYOUT_NONE;
      if (mode == MODE_D8_L4 || mode == MODE_D8_L4_B || mode == MODE_D8_L4_C ||
          mode == MODE_D8_L4_D || mode == MODE_D8_L4_E)
         l = LAYOUT_L4;
      else if (mode == MODE_D8_L8 || mode == MODE_D8_L8_B || mode == MODE_D8_L8_C)
         l = LAYOUT_L8;
      else if (mode == MODE_D8_L16)
         l = LAYOUT_L16;
      else if (mode == MODE_BYP_L12)
         l = LAYOUT_BYP;
      return l;
   endfunction
endpackage

`timescale 1ns/1ps
module word_packer
   import lane_map_pkg::*;
(
   input  wire logic [GROUP_SAMPLES-1:0][RAW_W-1:0] smp,
   output logic      [GROUP_WORDS-1:0][LANE_W-1:0]  word
);
   // msb first, split samples carry high bits into the earlier word
   always_comb begin
      word[0] = {smp[0], smp[1][11:8]};
      word[1] = {smp[1][7:0], smp[2][11:4]};
      word[2] = {smp[2][3:0], smp[3]};
   end
endmodule

//--- lane_receiver.sv
// receiver model counting mapped frames coming off the lanes
`timescale 1ns/1ps
module lane_receiver
   import lane_map_pkg::*;
(
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic              link_running,
   input  wire logic [MODE_W-1:0] link_mode_setting,
   input  wire logic              lane_valid,
   input  wire lane_bus_t         lanes,
   output logic [MODE_W-1:0]      rx_mode,
   output logic [15:0]            rx_count,
   output lane_bus_t              rx_lanes
);
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         rx_count <= 16'h0000;
         rx_mode  <= MODE_RESET;
      end else begin
         if (!link_running)
            rx_mode <= link_mode_setting; // follows the sender only while stopped
         if (lane_valid && link_running) begin
            rx_count <= rx_count + 16'h0001;
            rx_lanes <= lanes;
         end
      end
   end
endmodule

//--- tb.sv
// self-checking bench for the lane sample mapper
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("Error %s expected %h seen %h", nm, e, g); end end
module tb
   import lane_map_pkg::*;
;
   logic              sys_clk = 1'b0;
   logic              reset_n = 1'b0;
   logic              link_running = 1'b0;
   logic              frame_valid = 1'b0;
   logic [MODE_W-1:0] link_mode_setting = MODE_RESET;
   ddc_frame_t        ddc_frame = '0;
   byp_frame_t        byp_frame = '0;
   lane_bus_t         lanes;
   lane_bus_t         ex;
   logic              lane_valid;
   logic              mode_unsupported;
   logic              vex;
   layout_t           active_layout;
   logic [15:0]       rx_count;
   logic [MODE_W-1:0] rx_mode;
   int                fail_count = 0;
   int                n_compared = 0;
   int                n_frames = 0;
   int                seed = 32'hc070;
   logic [MODE_W-1:0] modes [12] = '{7'h0E, 7'h31, 7'h39, 7'h3C, 7'h43, 7'h0F, 7'h37,
                                     7'h3A, 7'h10, 7'h13, 7'h14, 7'h00};
   layout_t           lays [12] = '{LAYOUT_L4, LAYOUT_L4, LAYOUT_L4, LAYOUT_L4, LAYOUT_L4,
                                    LAYOUT_L8, LAYOUT_L8, LAYOUT_L8, LAYOUT_L16, LAYOUT_BYP,
                                    LAYOUT_NONE, LAYOUT_NONE};

   always #25 sys_clk = ~sys_clk;

   lane_sample_mapper uut (.sys_clk(sys_clk), .reset_n(reset_n),
      .link_mode_setting(link_mode_setting), .link_running(link_running),
      .frame_valid(frame_valid), .ddc_frame(ddc_frame), .byp_frame(byp_frame),
      .lanes(lanes), .lane_valid(lane_valid), .active_layout(active_layout),
      .mode_unsupported(mode_unsupported));

   lane_receiver rx (.sys_clk(sys_clk), .reset_n(reset_n), .link_running(link_running),
      .link_mode_setting(link_mode_setting), .lane_valid(lane_valid), .lanes(lanes),
      .rx_mode(rx_mode), .rx_count(rx_count), .rx_lanes());

   function automatic lane_bus_t expect_lanes(layout_t l, ddc_frame_t d, byp_frame_t b);
      lane_bus_t   r;
      logic [11:0] s [4];
      logic [47:0] w;
      int          n;
      r = '0;
      n = (l == LAYOUT_L4) ? 1 : (l == LAYOUT_L8) ? 2 : (l == LAYOUT_L16) ? 4 : 0;
      for (int k = 0; k < n; k++) begin
         r.a_side[k]   = {d.ai[k], d.or_a0[k]};
         r.a_side[k+n] = {d.aq[k], d.or_a1[k]};
         r.b_side[k]   = {d.bi[k], d.or_b0[k]};
         r.b_side[k+n] = {d.bq[k], d.or_b1[k]};
      end
      // h bit 0 picks the group of three lanes, bit 1 the odd side
      for (int h = 0; h < 4 && l == LAYOUT_BYP; h++) begin
         for (int j = 0; j < 4; j++)
            s[j] = b.smp[2*(4*(h%2)+j) + h/2];
         w = {s[0], s[1], s[2], s[3]};
         for (int m = 0; m < 3; m++) begin
            if (h < 2)
               r.a_side[3*(h%2)+m] = w[47-16*m -: 16];
            else
               r.b_side[3*(h%2)+m] = w[47-16*m -: 16];
         end
      end
      return r;
   endfunction

   task automatic new_frame(input bit hand);
      logic [255:0] v;
      for (int i = 0; i < 8; i++)
         v[32*i +: 32] = hand ? 32'h5A5AC3C3 : $random(seed);
      ddc_frame = v;
      byp_frame = v[191:0];
   endtask

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      #(50 * 5000);
      fail_count++;
      wrap_up();
   end

   initial begin
      repeat (2) @(negedge sys_clk);
      reset_n = 1'b1;
      `CHK("lane_valid", 1'b0, lane_valid)
      `CHK("layout", LAYOUT_NONE, active_layout)
      `CHK("unsupported", 1'b1, mode_unsupported)
      for (int m = 0; m < 12; m++) begin
         link_running      = 1'b0;
         link_mode_setting = modes[m];
         frame_valid       = 1'b1;
         @(negedge sys_clk);
         `CHK("stopped frame", 1'b0, lane_valid)
         `CHK("layout", lays[m], active_layout)
         `CHK("unsupported", lays[m] == LAYOUT_NONE, mode_unsupported)
         `CHK("receiver mode", modes[m], rx_mode)
         link_running = 1'b1;
         for (int k = 0; k < 4; k++) begin
            frame_valid = (k < 3);
            new_frame(k == 0);
            ex  = expect_lanes(lays[m], ddc_frame, byp_frame);
            vex = frame_valid && lays[m] != LAYOUT_NONE;
            n_frames += vex;
            link_mode_setting = modes[(m + 5) % 12];
            @(negedge sys_clk);
            `CHK("lane_valid", vex, lane_valid)
            `CHK("lanes", vex ? ex : '0, lanes)
            `CHK("layout held", lays[m], active_layout)
         end
         $display("test of mode %h done", modes[m]);
      end
      `CHK("frames received", n_frames[15:0], rx_count)
      wrap_up();
   end
endmodule
